// ---- src/acrc_top.sv ----
/*
  Converter control block: two write-only configuration registers loaded
  from a 12-bit write word, decode of their fields, and output coding of
  raw straight-binary conversion codes through a two-entry buffer.
  Assumes write strobe and data come from logic on core_clk, and raw
  samples arrive from the conversion pipeline on the same clock.
*/
`timescale 1ns/10ps

module acrc_top
  import acrc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                wr_en,
  input  wire logic [WORD_W-1:0]   wr_word,
  input  wire logic                raw_valid,
  input  wire logic [DATA_W-1:0]   raw_code,
  output logic                     raw_ready,
  output logic                     out_valid,
  output logic [DATA_W-1:0]        out_code,
  input  wire logic                out_ready,
  output acrc_pkg::acrc_cfg_s      cfg,
  output logic                     conv_active,
  output logic                     se_pick_valid,
  output acrc_pkg::acrc_input_e    se_pick
);
  import acrc_pkg::*;

  logic [DATA_W-1:0] input_and_mode_config;
  logic [DATA_W-1:0] format_and_reset_config;
  logic [1:0]        wr_addr;
  logic              twos_fmt;
  acrc_test_e        test_sel;
  logic [DATA_W-1:0] next_code;
  logic [DATA_W-1:0] buf_data [2];
  logic [1:0]        buf_cnt;
  logic              buf_rd;
  logic              push;
  logic              pop;
  logic [1:0]        next_cnt;
  logic              next_pd;

  // Address field of the write word
  assign wr_addr = wr_word[ADDR_HI_POS:ADDR_LO_POS];

  // Register 0 load; reserved addresses fall through untouched
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      input_and_mode_config <= REG0_RESET;
    else if (wr_en && wr_addr == ADDR_REG0)
      input_and_mode_config <= wr_word[DATA_W-1:0];
  end

  // Register 1 load
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      format_and_reset_config <= REG1_RESET;
    else if (wr_en && wr_addr == ADDR_REG1)
      format_and_reset_config <= wr_word[DATA_W-1:0];
  end

  assign twos_fmt = format_and_reset_config[FMT_SEL_POS];
  assign test_sel = acrc_test_e'(input_and_mode_config[TEST_HI_POS:TEST_LO_POS]);

  // Decoded configuration outputs, registered
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg           <= '0;
      conv_active   <= 1'b0;
      se_pick_valid <= 1'b0;
      se_pick       <= ACRC_IN_FIRST_POS;
    end
    else
    begin
      cfg.ext_ref      <= input_and_mode_config[REF_SEL_POS];
      cfg.reserved_bit <= 1'b0;
      cfg.power_down   <= input_and_mode_config[PD_POS];
      cfg.input_pick   <= input_and_mode_config[PICK_HI_POS:PICK_LO_POS];
      cfg.diff_count   <= input_and_mode_config[DIFF_HI_POS:DIFF_LO_POS];
      cfg.scan_en      <= input_and_mode_config[SCAN_POS];
      cfg.test_sel     <= test_sel;
      cfg.twos_fmt     <= twos_fmt;
      conv_active      <= !input_and_mode_config[PD_POS];
      se_pick_valid    <= !input_and_mode_config[SCAN_POS] &&
                          input_and_mode_config[DIFF_HI_POS:DIFF_LO_POS] == 2'b00;
      se_pick          <= acrc_input_e'(input_and_mode_config[PICK_HI_POS:PICK_LO_POS]);
    end
  end

  // Output coding: test voltages override, then format conversion
  always_comb
  begin
    unique case (test_sel)
      ACRC_TEST_NORMAL: next_code = raw_code;
      ACRC_TEST_UPPER:  next_code = CODE_BIN_TOP;
      ACRC_TEST_MID:    next_code = CODE_BIN_MID;
      ACRC_TEST_LOWER:  next_code = CODE_BIN_BOT;
    endcase
    if (twos_fmt)
      next_code = next_code ^ SIGN_FLIP;
  end

  // Two-entry buffer handshakes and its next fill level
  assign push     = raw_valid && raw_ready;
  assign pop      = out_valid && out_ready;
  assign next_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};

  // Power-down bit as it will stand after this edge
  assign next_pd = (wr_en && wr_addr == ADDR_REG0) ? wr_word[PD_POS]
                                                   : input_and_mode_config[PD_POS];

  // Registered intake ready; power-down stops intake but not draining
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      raw_ready <= 1'b0;
    else
      raw_ready <= (next_cnt != 2'd2) && !next_pd;
  end

  // Buffer storage and occupancy
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      buf_cnt <= 2'd0;
      buf_rd  <= 1'b0;
    end
    else
    begin
      if (push)
        buf_data[buf_rd ^ buf_cnt[0]] <= next_code;
      if (pop)
        buf_rd <= !buf_rd;
      buf_cnt <= next_cnt;
    end
  end

  // Registered output stage mirrors the buffer head
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_code  <= '0;
    end
    else
    begin
      out_valid <= 1'b0;
      out_code  <= out_code;
      if (buf_cnt - {1'b0, pop} != 2'd0)
      begin
        out_valid <= 1'b1;
        out_code  <= (pop || buf_cnt == 2'd0) ? buf_data[!buf_rd] : buf_data[buf_rd];
        if (buf_cnt == 2'd0)
          out_code <= next_code;
      end
      else if (push)
      begin
        out_valid <= 1'b1;
        out_code  <= next_code;
      end
      if (pop && buf_cnt == 2'd2)
        out_code <= buf_data[!buf_rd];
      else if (!pop && buf_cnt != 2'd0)
        out_code <= buf_data[buf_rd];
      else if (pop && buf_cnt == 2'd1 && push)
        out_code <= next_code;
    end
  end

  // Reserved address leaves registers unchanged
  chk_rsv_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_en && wr_addr[1] |=> $stable(input_and_mode_config) && $stable(format_and_reset_config))
    else $error("reserved address write changed a register");

  // Register 0 write reaches power-down output two cycles later
  chk_reg0_write_pd: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_en && wr_word[ADDR_HI_POS:ADDR_LO_POS] == ADDR_REG0 ##1 !wr_en
    |=> conv_active == !$past(wr_word[PD_POS], 2))
    else $error("register 0 write did not reach power-down state");

  // Reset value of differential count is one
  chk_diff_reset: assert property (@(posedge core_clk)
    !rst_n ##1 rst_n |-> input_and_mode_config == REG0_RESET)
    else $error("register 0 reset value wrong");

  // Upper test voltage codes
  chk_test_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    push && test_sel == ACRC_TEST_UPPER |-> next_code == (twos_fmt ? CODE_TWOS_TOP : CODE_BIN_TOP))
    else $error("upper test code wrong");

  // Midpoint code depends on format
  chk_mid_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    test_sel == ACRC_TEST_MID |-> next_code == (twos_fmt ? CODE_TWOS_MID : CODE_BIN_MID))
    else $error("midpoint code wrong");

  // Lower reference code
  chk_low_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    test_sel == ACRC_TEST_LOWER |-> next_code == (twos_fmt ? CODE_TWOS_BOT : CODE_BIN_BOT))
    else $error("lower code wrong");

  // Power-down blocks intake
  chk_pd_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
    input_and_mode_config[PD_POS] |-> !raw_ready)
    else $error("intake while powered down");

  // Reserved bit never reported
  chk_rsv_bit_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.reserved_bit == 1'b0)
    else $error("reserved bit reported set");

  // Stalled output holds its word
  chk_out_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_code))
    else $error("stalled output changed");

  // Register 0 takes the ten value bits of an addressed write
  chk_reg0_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_en && wr_addr == ADDR_REG0 |=> input_and_mode_config == $past(wr_word[DATA_W-1:0]))
    else $error("register 0 write not stored");

  // Register 1 takes the ten value bits of an addressed write
  chk_reg1_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_en && wr_addr == ADDR_REG1 |=> format_and_reset_config == $past(wr_word[DATA_W-1:0]))
    else $error("register 1 write not stored");

  // Reference select reported one edge after the register
  chk_ref_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.ext_ref == $past(input_and_mode_config[REF_SEL_POS]))
    else $error("reference select not reported");

  // Power-down bit reported one edge after the register
  chk_pd_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.power_down == $past(input_and_mode_config[PD_POS]))
    else $error("power-down bit not reported");

  // Channel-select field reported one edge after the register
  chk_pick_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.input_pick == $past(input_and_mode_config[PICK_HI_POS:PICK_LO_POS]))
    else $error("channel select not reported");

  // Differential count reported one edge after the register
  chk_diff_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.diff_count == $past(input_and_mode_config[DIFF_HI_POS:DIFF_LO_POS]))
    else $error("differential count not reported");

  // Autoscan enable reported one edge after the register
  chk_scan_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.scan_en == $past(input_and_mode_config[SCAN_POS]))
    else $error("autoscan enable not reported");

  // Test field reported one edge after the register
  chk_test_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.test_sel == $past(test_sel))
    else $error("test field not reported");

  // Scan or differential use hides the single-ended pick
  chk_scan_hides_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.scan_en || cfg.diff_count != 2'b00 |-> !se_pick_valid)
    else $error("single-ended pick valid in scan or differential mode");

  // Single-ended pick agrees with the reported channel field
  chk_pick_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    se_pick_valid |-> se_pick == acrc_input_e'(cfg.input_pick))
    else $error("single-ended pick disagrees with channel field");

  // Normal binary mode passes the raw code unchanged
  chk_normal_binary: assert property (@(posedge core_clk) disable iff (!rst_n)
    push && test_sel == ACRC_TEST_NORMAL && !twos_fmt |-> next_code == raw_code)
    else $error("binary code altered");

  // Normal two's complement mode inverts only the top bit
  chk_normal_twos: assert property (@(posedge core_clk) disable iff (!rst_n)
    push && test_sel == ACRC_TEST_NORMAL && twos_fmt |-> next_code ==
      {~raw_code[DATA_W-1], raw_code[DATA_W-2:0]})
    else $error("two's complement code wrong");

  // Converter activity is the inverse of the reported power-down
  chk_active_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> conv_active == !cfg.power_down)
    else $error("activity disagrees with power-down");

  // Output format reported one edge after register 1
  chk_fmt_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> cfg.twos_fmt == $past(format_and_reset_config[FMT_SEL_POS]))
    else $error("output format not reported");

endmodule : acrc_top

// ---- src/acrc_pkg.sv ----
/*
  Package for the converter control block: register addressing, field
  positions, reset values, output codes and the carrier structs.
  Assumes a 12-bit write word and a 10-bit conversion result.
*/
package acrc_pkg;

  localparam int DATA_W = 10;
  localparam int WORD_W = 12;

  // Register address field of the write word
  localparam int ADDR_HI_POS = 11;
  localparam int ADDR_LO_POS = 10;
  localparam logic [1:0] ADDR_REG0 = 2'h0;
  localparam logic [1:0] ADDR_REG1 = 2'h1;

  // Field positions in input_and_mode_config
  localparam int REF_SEL_POS   = 0;
  localparam int RSV_POS       = 1;
  localparam int PD_POS        = 2;
  localparam int PICK_LO_POS   = 3;
  localparam int PICK_HI_POS   = 4;
  localparam int DIFF_LO_POS   = 5;
  localparam int DIFF_HI_POS   = 6;
  localparam int SCAN_POS      = 7;
  localparam int TEST_LO_POS   = 8;
  localparam int TEST_HI_POS   = 9;

  // Field positions in format_and_reset_config
  localparam int FMT_SEL_POS   = 7;

  // Reset values
  localparam logic [9:0] REG0_RESET = 10'h020;
  localparam logic [9:0] REG1_RESET = 10'h000;

  // Output codes
  localparam logic [9:0] CODE_BIN_TOP  = 10'h3FF;
  localparam logic [9:0] CODE_BIN_MID  = 10'h200;
  localparam logic [9:0] CODE_BIN_BOT  = 10'h000;
  localparam logic [9:0] CODE_TWOS_TOP = 10'h1FF;
  localparam logic [9:0] CODE_TWOS_MID = 10'h000;
  localparam logic [9:0] CODE_TWOS_BOT = 10'h200;
  localparam logic [9:0] SIGN_FLIP     = 10'h200;

  // Test field encodings
  typedef enum logic [1:0] {
    ACRC_TEST_NORMAL = 2'b00,
    ACRC_TEST_UPPER  = 2'b01,
    ACRC_TEST_MID    = 2'b10,
    ACRC_TEST_LOWER  = 2'b11
  } acrc_test_e;

  // Single-ended input selection
  typedef enum logic [1:0] {
    ACRC_IN_FIRST_POS  = 2'b00,
    ACRC_IN_FIRST_NEG  = 2'b01,
    ACRC_IN_SECOND_POS = 2'b10,
    ACRC_IN_SECOND_NEG = 2'b11
  } acrc_input_e;

  // Decoded configuration
  typedef struct packed {
    acrc_test_e  test_sel;
    logic        scan_en;
    logic [1:0]  diff_count;
    logic [1:0]  input_pick;
    logic        power_down;
    logic        reserved_bit;
    logic        ext_ref;
    logic        twos_fmt;
  } acrc_cfg_s;

  // Result word with validity
  typedef struct packed {
    logic        valid;
    logic [9:0]  code;
  } acrc_sample_s;

endpackage : acrc_pkg

// ---- testbench/acrc_host_sink.sv ----
/*
  Host-side sink for coded results, able to stall on request.
  Assumes results arrive on core_clk with a valid/ready handshake.
*/
`timescale 1ns/10ps

module acrc_host_sink
  import acrc_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        out_valid,
  input  wire logic [acrc_pkg::DATA_W-1:0] out_code,
  input  wire logic                        stall,
  output logic                             out_ready
);
  logic [DATA_W-1:0] rx_q[$];

  // Ready withheld while stalling
  assign out_ready = !stall;

  // Collect every word taken
  always @(posedge core_clk)
  begin
    if (rst_n && out_valid && out_ready)
      rx_q.push_back(out_code);
  end
endmodule : acrc_host_sink

// ---- testbench/tb.sv ----
/*
  Self-checking bench for the converter control block.
  Assumes one core clock and inputs driven at the falling edge.
*/
`timescale 1ns/10ps

module tb;
  import acrc_pkg::*;
  logic              core_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0;
  logic              raw_valid = 1'b0, stall = 1'b0;
  logic [WORD_W-1:0] wr_word = 12'h000;
  logic [DATA_W-1:0] raw_code = 10'h000, out_code;
  logic              raw_ready, out_valid, out_ready, conv_active, se_pick_valid;
  acrc_cfg_s         cfg;
  acrc_input_e       se_pick;
  int                errors = 0;
  int                cmp_count = 0;

  // Free-running core clock
  always #25 core_clk = ~core_clk;

  acrc_top dut (.core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en), .wr_word(wr_word),
    .raw_valid(raw_valid), .raw_code(raw_code), .raw_ready(raw_ready),
    .out_valid(out_valid), .out_code(out_code), .out_ready(out_ready), .cfg(cfg),
    .conv_active(conv_active), .se_pick_valid(se_pick_valid), .se_pick(se_pick));

  acrc_host_sink sink (.core_clk(core_clk), .rst_n(rst_n), .out_valid(out_valid),
    .out_code(out_code), .stall(stall), .out_ready(out_ready));

  task finish_test;
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Expected decode of a register 0 value and format bit
  function automatic acrc_cfg_s exp_cfg(input logic [9:0] v, input logic f);
    acrc_cfg_s e;
    e = {v[9:2], 1'b0, v[0], f};
    return e;
  endfunction : exp_cfg

  // One write word; decode visible two edges later
  task wr(input logic [1:0] a, input logic [9:0] v);
    wr_en = 1'b1;
    wr_word = {a, v};
    @(negedge core_clk);
    wr_en = 1'b0;
    @(negedge core_clk);
  endtask : wr

  // Offer one raw word and wait until it is taken
  task send(input logic [9:0] c);
    int i;
    raw_valid = 1'b1;
    raw_code = c;
    for (i = 0; i < 50 && raw_ready !== 1'b1; i++)
      @(negedge core_clk);
    if (raw_ready !== 1'b1)
    begin
      errors++;
      finish_test();
    end
    @(negedge core_clk);
  endtask : send

  // Wait for n words at the sink, then compare the first three in order
  task drain(input int n, input logic [9:0] e0, input logic [9:0] e1, input logic [9:0] e2);
    int i;
    raw_valid = 1'b0;
    for (i = 0; i < 50 && sink.rx_q.size() < n; i++)
      @(negedge core_clk);
    if (sink.rx_q.size() < n)
    begin
      errors++;
      finish_test();
    end
    chk(16'(sink.rx_q.pop_front()), 16'(e0));
    chk(16'(sink.rx_q.pop_front()), 16'(e1));
    chk(16'(sink.rx_q.pop_front()), 16'(e2));
  endtask : drain

  task t_reset;
    chk(16'(cfg), 16'(exp_cfg(10'h020, 1'b0)));
    chk(16'(conv_active), 16'h0001);
  endtask : t_reset

  task t_fields;
    wr(2'h0, 10'h3D4);
    chk(16'(cfg), 16'(exp_cfg(10'h3D4, 1'b0)));
    chk(16'({conv_active, raw_ready}), 16'h0000);
    wr(2'h2, 10'h001);
    wr(2'h3, 10'h0FF);
    chk(16'(cfg), 16'(exp_cfg(10'h3D4, 1'b0)));
    wr(2'h0, 10'h002);
    chk(16'(cfg), 16'(exp_cfg(10'h002, 1'b0)));
    wr(2'h0, 10'h021);
    chk(16'(cfg), 16'(exp_cfg(10'h021, 1'b0)));
    chk(16'({conv_active, raw_ready}), 16'h0003);
  endtask : t_fields

  task t_pick;
    for (int p = 0; p < 4; p++)
    begin
      wr(2'h0, 10'(p << 3));
      chk(16'({se_pick_valid, se_pick}), 16'(4 + p));
    end
    wr(2'h0, 10'h088);
    chk(16'(se_pick_valid), 16'h0000);
  endtask : t_pick

  // Every format and test mode over top, midpoint and bottom
  task t_coding;
    logic [9:0] e[3];
    for (int f = 0; f < 2; f++)
      for (int t = 0; t < 4; t++)
      begin
        wr(2'h1, 10'(f << 7));
        wr(2'h0, 10'(32'h020 | (t << 8)));
        e = '{10'h3FF, 10'h200, 10'h000};
        foreach (e[k])
        begin
          if (t != 0)
            e[k] = (t == 1) ? 10'h3FF : ((t == 2) ? 10'h200 : 10'h000);
          e[k] = e[k] ^ ((f == 1) ? 10'h200 : 10'h000);
        end
        send(10'h3FF);
        send(10'h200);
        send(10'h000);
        drain(3, e[0], e[1], e[2]);
      end
  endtask : t_coding

  // Stalled sink fills the buffer, then order survives the drain
  task t_buffer;
    wr(2'h1, 10'h000);
    wr(2'h0, 10'h020);
    stall = 1'b1;
    send(10'h011);
    send(10'h122);
    chk(16'(raw_ready), 16'h0000);
    stall = 1'b0;
    send(10'h233);
    drain(3, 10'h011, 10'h122, 10'h233);
  endtask : t_buffer

  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_reset();
    t_fields();
    t_pick();
    t_coding();
    t_buffer();
    finish_test();
  end
endmodule : tb
